/* File: rtl/mii_pin_pkg.sv */
// Constants and carrier types for the MII pin state and indicator logic.
// Assumes a single 10 MHz system clock and an active-low asynchronous reset.
//
// Notes on behaviour
// - Receive data, valid, error, collision and carrier go low in reset and power-down.
// - Both MII clocks are held high in reset and keep running in power-down.
// - Transmit inputs are weakly pulled down outside normal mode; isolate floats all MII outputs with pull-down.
// - Each indicator pin shows one status condition, or a fixed on or off level, picked by its configuration field.
// - Indicator pins are sampled as configuration straps before driving indicators.
// - Hardware reset is active low; internal reset stretches about 258 us after release.
package mii_pin_pkg;

   // =========================================================================
   // Timing.
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned RESET_STRETCH_NS = 258_000;
   localparam int unsigned RESET_STRETCH_CYC =
      (RESET_STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned STRETCH_W = 12;

   // =========================================================================
   // Indicator selection codes, four bits per pin.
   localparam int unsigned LED_COUNT = 3;
   localparam int unsigned LED_SEL_W = 4;
   localparam logic [3:0] LED_SEL_LINK = 4'h0;
   localparam logic [3:0] LED_SEL_ACT = 4'h1;
   localparam logic [3:0] LED_SEL_SPEED = 4'h2;
   localparam logic [3:0] LED_SEL_DUPLEX = 4'h3;
   localparam logic [3:0] LED_SEL_COL = 4'h4;
   localparam logic [3:0] LED_SEL_ON = 4'h5;
   localparam logic [3:0] LED_SEL_OFF = 4'h6;

   // =========================================================================
   // Pin modes in order of priority.
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_ISOLATE = 2'b01,
      MODE_POWER_DOWN = 2'b10,
      MODE_HW_RESET = 2'b11
   } pin_mode_e;

   // MII receive-side output bundle.
   typedef struct packed {
      logic [3:0] rxd;
      logic rx_dv;
      logic rx_er;
      logic col;
      logic crs;
      logic tx_clk;
      logic rx_clk;
   } mii_out_s;

   // Link status conditions that indicators can show.
   typedef struct packed {
      logic link;
      logic activity;
      logic speed_100;
      logic full_duplex;
      logic collision;
   } link_status_s;

endpackage

/* File: rtl/reset_stretch.sv */
// Stretches the internal reset for a fixed count after the pin is released.
// Assumes the pin is synchronous to clk_sys.
`timescale 1ns/1ps
module reset_stretch
   import mii_pin_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hw_reset_n,
   output logic internal_reset
);

   typedef struct packed {
      logic [STRETCH_W-1:0] count;
      logic busy;
   } stretch_s;

   stretch_s state_r;
   stretch_s state_nxt;

   // =========================================================================
   // Counter reloads while the pin is low, then counts down to release.
   always_comb begin
      state_nxt = state_r;
      if (!hw_reset_n) begin
         state_nxt.count = STRETCH_W'(RESET_STRETCH_CYC);
         state_nxt.busy = 1'b1;
      end else if (state_r.count != '0) begin
         state_nxt.count = state_r.count - 1'b1;
      end else begin
         state_nxt.busy = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '{count: STRETCH_W'(RESET_STRETCH_CYC), busy: 1'b1};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign internal_reset = state_r.busy;

   // Release must not come within 8 cycles after the pin rises.
   AST_STRETCH_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(hw_reset_n) |-> internal_reset [*8])
      else $error("Internal reset released too early.");

endmodule // reset_stretch

/* File: rtl/mii_pin_ctrl.sv */
// MII pin state control, strap capture and indicator drivers.
// Assumes the MAC-facing pins are resolved by the pad ring from the enables.
`timescale 1ns/1ps
module mii_pin_ctrl
   import mii_pin_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hw_reset_n,
   input wire logic soft_power_down,
   input wire logic isolate,
   input wire mii_out_s mii_core,
   input wire logic [3:0] txd_pin,
   input wire logic tx_en_pin,
   output logic [3:0] txd_core,
   output logic tx_en_core,
   output logic tx_pulldown_en,
   output mii_out_s mii_out,
   output logic mii_oe,
   output logic mii_pulldown_en,
   input wire link_status_s link_status,
   input wire logic [LED_COUNT*LED_SEL_W-1:0] led_config,
   input wire logic [LED_COUNT-1:0] indicator_strap_in,
   output logic [LED_COUNT-1:0] indicator_strap_out,
   output logic [LED_COUNT-1:0] indicator_strap_oe,
   output logic [LED_COUNT-1:0] strap_value,
   output logic internal_reset
);

   typedef struct packed {
      pin_mode_e mode;
      mii_out_s pins;
      logic oe;
      logic [LED_COUNT-1:0] straps;
      logic straps_taken;
      logic [LED_COUNT-1:0] leds;
   } ctrl_s;

   ctrl_s state_r;
   ctrl_s state_nxt;
   logic [LED_COUNT-1:0] led_level;

   // Maps a selection code onto the chosen status condition.
   function automatic logic led_pick(input logic [3:0] sel,
                                     input link_status_s st);
      logic val;
      val = 1'b0;
      case (sel)
         LED_SEL_LINK: val = st.link;
         LED_SEL_ACT: val = st.activity;
         LED_SEL_SPEED: val = st.speed_100;
         LED_SEL_DUPLEX: val = st.full_duplex;
         LED_SEL_COL: val = st.collision;
         LED_SEL_ON: val = 1'b1;
         default: val = 1'b0;
      endcase
      return val;
   endfunction

   // =========================================================================
   // Internal reset stretcher.
   reset_stretch u_stretch (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .hw_reset_n(hw_reset_n),
      .internal_reset(internal_reset)
   );

   // =========================================================================
   // Indicator selection, one per pin.
   genvar gi;
   generate
      for (gi = 0; gi < LED_COUNT; gi++) begin : g_led
         assign led_level[gi] = led_pick(
            led_config[gi*LED_SEL_W +: LED_SEL_W], link_status);
      end
   endgenerate

   // =========================================================================
   // Next state: mode priority, pin values and strap capture.
   always_comb begin
      state_nxt = state_r;
      // Reset outranks power-down, which outranks isolate.
      if (internal_reset) begin
         state_nxt.mode = MODE_HW_RESET;
      end else if (soft_power_down) begin
         state_nxt.mode = MODE_POWER_DOWN;
      end else if (isolate) begin
         state_nxt.mode = MODE_ISOLATE;
      end else begin
         state_nxt.mode = MODE_NORMAL;
      end
      state_nxt.oe = 1'b1;
      case (state_nxt.mode)
         MODE_HW_RESET: begin
            state_nxt.pins = '0;
            state_nxt.pins.tx_clk = 1'b1;
            state_nxt.pins.rx_clk = 1'b1;
         end
         MODE_POWER_DOWN: begin
            state_nxt.pins = '0;
            state_nxt.pins.tx_clk = mii_core.tx_clk;
            state_nxt.pins.rx_clk = mii_core.rx_clk;
         end
         MODE_ISOLATE: begin
            state_nxt.pins = '0;
            state_nxt.oe = 1'b0;
         end
         MODE_NORMAL: begin
            state_nxt.pins = mii_core;
         end
         default: begin
            state_nxt.pins = '0;
         end
      endcase
      // Straps are read while reset is held, so the pins are still inputs.
      if (internal_reset) begin
         state_nxt.straps = indicator_strap_in;
         state_nxt.straps_taken = 1'b1;
      end
      state_nxt.leds = led_level;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // One constant literal: data pins low, both clocks high.
         state_r <= '{mode: MODE_HW_RESET,
                      pins: '{rxd: 4'h0, rx_dv: 1'b0, rx_er: 1'b0,
                              col: 1'b0, crs: 1'b0, tx_clk: 1'b1,
                              rx_clk: 1'b1},
                      oe: 1'b1, straps: '0, straps_taken: 1'b0,
                      leds: '0};
      end else begin
         state_r <= state_nxt;
      end
   end

   // =========================================================================
   // Output wiring. Pull-downs hold the transmit inputs in every quiet mode.
   assign mii_out = state_r.pins;
   assign mii_oe = state_r.oe;
   assign mii_pulldown_en = (state_r.mode == MODE_ISOLATE);
   assign tx_pulldown_en = (state_r.mode != MODE_NORMAL);
   assign txd_core = (state_r.mode == MODE_NORMAL) ? txd_pin : 4'h0;
   assign tx_en_core = (state_r.mode == MODE_NORMAL) & tx_en_pin;
   // Indicators drive only after reset, so a strap is never fought.
   assign indicator_strap_out = state_r.leds;
   assign indicator_strap_oe = {LED_COUNT{!internal_reset}};
   assign strap_value = state_r.straps;

   // =========================================================================
   // Assertions.
   AST_RESET_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      internal_reset |=> (mii_out.rxd == 4'h0 && !mii_out.crs))
      else $error("Receive outputs not low in reset.");
   AST_PD_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!internal_reset && soft_power_down) |=>
      (!mii_out.rx_dv && !mii_out.rx_er && !mii_out.col))
      else $error("Receive outputs not low in power-down.");
   AST_RESET_CLK_HIGH: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      internal_reset |=> (mii_out.tx_clk && mii_out.rx_clk))
      else $error("Clocks not high in reset.");
   AST_PD_CLK_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!internal_reset && soft_power_down) |=>
      mii_out.tx_clk == $past(mii_core.tx_clk))
      else $error("Transmit clock stopped in power-down.");
   AST_ISOLATE_FLOAT: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (!internal_reset && !soft_power_down && isolate) |=>
      (!mii_oe && mii_pulldown_en && tx_pulldown_en))
      else $error("Outputs driven in isolate.");
   AST_LED_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (led_config[3:0] == LED_SEL_LINK) |=>
      state_r.leds[0] == $past(link_status.link))
      else $error("Indicator does not follow selection.");
   AST_STRAP_CAPTURE: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      internal_reset |=> (strap_value == $past(indicator_strap_in)))
      else $error("Strap value not captured in reset.");
   AST_STRAP_NO_DRIVE: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      internal_reset |-> indicator_strap_oe == '0)
      else $error("Indicator driven during reset.");
   AST_PRIORITY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (internal_reset && soft_power_down && isolate) |=>
      (mii_oe && state_r.mode == MODE_HW_RESET))
      else $error("Mode priority wrong.");

   COV_RESET: cover property (@(posedge clk_sys) $fell(internal_reset));
   COV_PD: cover property (@(posedge clk_sys)
      state_r.mode == MODE_POWER_DOWN);
   COV_ISO: cover property (@(posedge clk_sys)
      state_r.mode == MODE_ISOLATE);

endmodule // mii_pin_ctrl

/* File: verif/mac_model.sv */
// MAC-side model that drives the transmit pins toward the block.
// Assumes the bench gives the drive value and whether the MAC drives.
`timescale 1ns/1ps
module mac_model
   import mii_pin_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [4:0] tx_drive,
   input wire logic tx_drive_en,
   input wire logic tx_pulldown_en,
   output logic [3:0] txd_pin,
   output logic tx_en_pin
);
   // ======================================================
   // Last seen line levels, so a floating line never keeps a stale value.
   logic [4:0] last_r = 5'h00;
   always_ff @(posedge clk_sys) begin
      last_r <= {tx_en_pin, txd_pin};
   end
   // A released line sits at the weak pull-down when the block applies it.
   // Without the pull-down it toggles, since a floating pin has no level.
   always_comb begin
      if (tx_drive_en)
         {tx_en_pin, txd_pin} = tx_drive;
      else if (tx_pulldown_en)
         {tx_en_pin, txd_pin} = 5'h00;
      else
         {tx_en_pin, txd_pin} = ~last_r;
   end
endmodule // mac_model

/* File: verif/mii_pin_ctrl_tb.sv */
// Self-checking bench for the MII pin state and indicator block.
// Assumes the package constants and a MAC model on the transmit pins.
`timescale 1ns/1ps
module mii_pin_ctrl_tb import mii_pin_pkg::*;;
   // ======================================================
   // Stimulus and observed signals.
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hw_reset_n = 1'b1;
   logic soft_power_down = 1'b0;
   logic isolate = 1'b0;
   mii_out_s mii_core = mii_out_s'(9'h1f6);
   link_status_s link_status = link_status_s'(5'h15);
   logic [11:0] led_config = 12'h000;
   logic [2:0] strap_board = 3'h5;
   logic [4:0] tx_drive = 5'h1b;
   logic tx_drive_en = 1'b1;
   logic [3:0] txd_pin, txd_core;
   logic tx_en_pin, tx_en_core, tx_pulldown_en, mii_oe, mii_pulldown_en;
   logic internal_reset;
   mii_out_s mii_out;
   logic [2:0] indicator_strap_in, indicator_strap_out;
   logic [2:0] indicator_strap_oe, strap_value;
   logic [8:0] side_v;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   // Board strap resistors win only while the block is not driving.
   assign indicator_strap_in = (indicator_strap_oe & indicator_strap_out)
      | (~indicator_strap_oe & strap_board);
   assign side_v = {txd_core, tx_en_core, tx_pulldown_en, mii_oe,
      mii_pulldown_en, 1'b0};
   mii_pin_ctrl mii_pin_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .hw_reset_n(hw_reset_n), .soft_power_down(soft_power_down),
      .isolate(isolate), .mii_core(mii_core), .txd_pin(txd_pin),
      .tx_en_pin(tx_en_pin), .txd_core(txd_core), .tx_en_core(tx_en_core),
      .tx_pulldown_en(tx_pulldown_en), .mii_out(mii_out), .mii_oe(mii_oe),
      .mii_pulldown_en(mii_pulldown_en), .link_status(link_status),
      .led_config(led_config), .indicator_strap_in(indicator_strap_in),
      .indicator_strap_out(indicator_strap_out),
      .indicator_strap_oe(indicator_strap_oe), .strap_value(strap_value),
      .internal_reset(internal_reset));
   mac_model mac_model_i (.clk_sys(clk_sys), .tx_drive(tx_drive),
      .tx_drive_en(tx_drive_en), .tx_pulldown_en(tx_pulldown_en),
      .txd_pin(txd_pin), .tx_en_pin(tx_en_pin));
   // ======================================================
   // Clock and hang guard; the tests need about 5200 cycles.
   // The bench clock stands in for the reference the system supplies.
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 12000) begin
         n_fail++;
         stop_test();
      end
   end
   // ======================================================
   // Shared compare, stretch wait and verdict.
   task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                      input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_stretch();
      int n;
      n = 0;
      while (internal_reset !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
         if (n == 100)
            chk(mii_out, 9'h003, "pins in stretch");
      end
      chk(9'(n >= RESET_STRETCH_CYC && n <= RESET_STRETCH_CYC + 2), 9'h1,
          "stretch length");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ======================================================
   // Scenarios.
   task automatic t_reset();
      chk(mii_out, 9'h003, "reset pins");
      chk(side_v, 9'h00c, "reset tx side");
      chk({6'h0, indicator_strap_oe}, 9'h000, "strap oe in reset");
      rst_n = 1'b1;
      wait_stretch();
      @(negedge clk_sys);
      chk({6'h0, strap_value}, 9'h005, "strap capture");
      chk(mii_out, 9'h1f6, "normal pins");
      chk(side_v, 9'h174, "normal tx side");
      $display("test reset done");
   endtask
   task automatic t_power_isolate();
      soft_power_down = 1'b1;
      @(negedge clk_sys);
      chk(mii_out, 9'h002, "power-down pins");
      chk(side_v, 9'h00c, "power-down tx side");
      // The MAC lets go of its lines; only the pull-down holds them.
      tx_drive_en = 1'b0;
      @(negedge clk_sys);
      chk({4'h0, tx_en_pin, txd_pin}, 9'h000, "released tx pins");
      chk(side_v, 9'h00c, "released tx side");
      tx_drive_en = 1'b1;
      mii_core = mii_out_s'(9'h1f5);
      @(negedge clk_sys);
      chk(mii_out, 9'h001, "clocks running");
      mii_core = mii_out_s'(9'h1f6);
      isolate = 1'b1;
      @(negedge clk_sys);
      chk(side_v, 9'h00c, "power-down over isolate");
      strap_board = 3'h2;
      hw_reset_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(mii_out, 9'h003, "reset over power-down");
      chk(side_v, 9'h00c, "reset tx side");
      hw_reset_n = 1'b1;
      wait_stretch();
      @(negedge clk_sys);
      chk({6'h0, strap_value}, 9'h002, "strap recapture");
      chk(mii_out, 9'h002, "power-down after reset");
      soft_power_down = 1'b0;
      @(negedge clk_sys);
      chk(mii_out, 9'h000, "isolate pins");
      chk(side_v, 9'h00a, "isolate enables");
      isolate = 1'b0;
      @(negedge clk_sys);
      chk(side_v, 9'h174, "back to normal");
      $display("test modes done");
   endtask
   task automatic t_leds();
      logic [7:0] lvl;
      logic [2:0] exp;
      for (int p = 0; p < 2; p++) begin
         link_status = link_status_s'(p == 0 ? 5'h15 : 5'h0a);
         lvl = {3'b001, link_status.collision, link_status.full_duplex,
                link_status.speed_100, link_status.activity,
                link_status.link};
         for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 3; i++) begin
               led_config[4*i +: 4] = 4'((c + i) % 8);
               exp[i] = lvl[(c + i) % 8];
            end
            @(negedge clk_sys);
            chk({6'h0, indicator_strap_out}, {6'h0, exp}, "led");
            chk({6'h0, indicator_strap_oe}, 9'h007, "led drive");
         end
      end
      $display("test leds done");
   endtask
   // Main sequence: reset held 20 cycles, then each scenario.
   initial begin
      repeat (20) @(negedge clk_sys);
      t_reset();
      t_power_isolate();
      t_leds();
      stop_test();
   end
endmodule // mii_pin_ctrl_tb
